// >>> rtl/ipvs_pkg.sv
// Constants, register map and state layout of the internal preset velocity selector
package ipvs_pkg;
	localparam logic [7:0] A_MODE = 8'h00;
	localparam logic [7:0] A_SENSE = 8'h04;
	localparam logic [7:0] A_FUNC0 = 8'h08;
	localparam logic [7:0] A_FUNC5 = 8'h1c;
	localparam logic [7:0] A_PRESET0 = 8'h20;
	localparam logic [7:0] A_PRESET7 = 8'h3c;
	localparam logic [7:0] A_RUP = 8'h40;
	localparam logic [7:0] A_RDN = 8'h44;
	localparam logic [7:0] A_STAT = 8'h48;
	localparam logic [7:0] A_REF = 8'h4c;
	localparam int N_IN = 6;
	localparam int N_PRE = 8;
	localparam logic [7:0] MODE_RST = 8'h15;
	localparam logic [7:0] MODE_IVEL = 8'h0f;
	localparam logic [5:0] FN_RST = 6'h00;
	localparam logic [5:0] FN_SEL0 = 6'h1b;
	localparam logic [5:0] FN_SEL1 = 6'h1d;
	localparam logic [5:0] FN_SEL2 = 6'h1f;
	localparam logic [5:0] FN_RUN = 6'h21;
	localparam logic [5:0] FN_DIR = 6'h23;
	localparam logic signed [7:0] PRE_MAX = 8'sh64;
	localparam logic signed [7:0] PRE_MIN = -8'sh64;
	// Presets 8..1, in rps
	localparam logic [63:0] PRE_RST = 64'h32_28_23_1e_19_14_0a_00;
	// Rates in milli-rps/s
	localparam logic [22:0] RATE_MIN = 23'h0000a7;
	localparam logic [22:0] RATE_MAX = 23'h4c4b40;
	localparam logic [22:0] RATE_RST = 23'h0186a0;
	// Speed reference unit is one micro-rps
	localparam logic signed [27:0] URPS = 28'sh00f4240;
	localparam int TICK_US = 1000;
	localparam int CLK_MHZ = 40;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;
	typedef struct packed {
		logic [N_IN-1:0]      sy1;
		logic [N_IN-1:0]      sy2;
		logic [7:0]           mode;
		logic                 sense;
		logic [N_IN-1:0][5:0] func;
		logic [N_PRE-1:0][7:0] pre;
		logic [22:0]          rup;
		logic [22:0]          rdn;
		logic [15:0]          tcnt;
		logic signed [27:0]   ref_v;
		logic                 ccw;
		logic                 run;
		logic                 wp;
		logic                 rp;
		logic [7:0]           addr;
		logic                 rdy;
		logic [31:0]          rdata;
	} ipvs_st_s;
endpackage

// >>> rtl/ipvs_top.sv
// Internal preset velocity selector with AHB-Lite register slave
//
// How it works
// - Eight stored presets; digital input levels pick the active one.
// - Velocity runs only while main control mode equals 15.
// - Each of six input lines has its own function code register.
// - Codes 27/28,29/30,31/32 select bits, 33/34 run; odd closed-active.
// - Presets are signed and clamped to -100..100 rps.
// - Presets reset to 0,10,20,25,30,35,40,50 rps.
// - Separate up and down ramp rates, 0.167..5000 rps/s, default 100.
// - Without direction input, preset sign sets the direction.
// - With direction input, preset magnitude is used, input sets direction.
// - Direction function codes 35 closed-active, 36 open-active.
// - No direction input: sense 0 positive CW; sense 1 inverts.
// - Direction input: sense 0 active CW; sense 1 active CCW.
module ipvs_top
	import ipvs_pkg::*;
#(
	parameter int TICK = TICK_CYC
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               ce,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic [31:0]             hrdata,
	output logic                    hresp,
	input  wire logic [N_IN-1:0]    gen_in,
	output logic signed [27:0]      speed_ref,
	output logic                    dir_ccw,
	output logic                    vel_run
);
	ipvs_st_s           s;
	ipvs_st_s           n;
	logic [2:0]         sel_v;
	logic               run_v;
	logic               dir_on;
	logic               dir_asg;
	logic               act_v;
	logic [2:0]         idx;
	logic signed [7:0]  pre_s;
	logic signed [27:0] mag;
	logic signed [27:0] tgt;
	logic signed [28:0] diff;
	logic [22:0]        rate;
	logic [22:0]        wrate;
	logic [1:0]         hit_s0;
	logic [1:0]         hit_s1;
	logic [1:0]         hit_s2;
	logic [1:0]         hit_run;
	logic [1:0]         hit_dir;
	logic               up;
	logic               tick;
	logic [7:0]         wa;
	logic signed [31:0] wd_s;
	logic [31:0]        rd_v;

	// Bit 1 = line carries this function, bit 0 = function active
	function automatic logic [1:0] fn_hit(input logic [5:0] c, input logic [5:0] b,
		input logic lv);
		if (c == b) begin
			return {1'b1, lv};
		end
		if (c == b + 6'h01) begin
			return {1'b1, ~lv};
		end
		return 2'b00;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = s;
		sel_v = 3'h0;
		run_v = 1'b0;
		dir_on = 1'b0;
		dir_asg = 1'b0;
		hit_s0 = 2'b00;
		hit_s1 = 2'b00;
		hit_s2 = 2'b00;
		hit_run = 2'b00;
		hit_dir = 2'b00;
		// Inputs pass two flops before decoding
		n.sy1 = gen_in;
		n.sy2 = s.sy1;
		for (int i = 0; i < N_IN; i++) begin
			hit_s0 = fn_hit(s.func[i], FN_SEL0, s.sy2[i]);
			hit_s1 = fn_hit(s.func[i], FN_SEL1, s.sy2[i]);
			hit_s2 = fn_hit(s.func[i], FN_SEL2, s.sy2[i]);
			hit_run = fn_hit(s.func[i], FN_RUN, s.sy2[i]);
			hit_dir = fn_hit(s.func[i], FN_DIR, s.sy2[i]);
			sel_v[0] = sel_v[0] | hit_s0[0];
			sel_v[1] = sel_v[1] | hit_s1[0];
			sel_v[2] = sel_v[2] | hit_s2[0];
			run_v = run_v | hit_run[0];
			dir_on = dir_on | hit_dir[0];
			dir_asg = dir_asg | hit_dir[1];
		end
		act_v = run_v && (s.mode == MODE_IVEL);
		idx = sel_v;
		pre_s = $signed(s.pre[idx]);
		mag = 28'(pre_s * URPS);
		if (dir_asg) begin
			// Magnitude only; active input means positive reference
			if (mag < 0) begin
				mag = -mag;
			end
			tgt = dir_on ? mag : -mag;
		end else begin
			tgt = mag;
		end
		if (!act_v) begin
			tgt = 28'sh0;
		end

		////////////////////////////////////////////////////////////////////////
		// Ramp: one step per 1 ms tick; rate in milli-rps/s equals step in micro-rps
		tick = (s.tcnt == 16'(TICK - 1));
		n.tcnt = tick ? 16'h0 : s.tcnt + 16'h1;
		up = (tgt > s.ref_v && s.ref_v >= 0) || (tgt < s.ref_v && s.ref_v <= 0);
		rate = up ? s.rup : s.rdn;
		diff = 29'(tgt) - 29'(s.ref_v);
		if (tick) begin
			if (diff > $signed({6'h0, rate})) begin
				n.ref_v = s.ref_v + 28'(rate);
			end else if (diff < -$signed({6'h0, rate})) begin
				n.ref_v = s.ref_v - 28'(rate);
			end else begin
				n.ref_v = tgt;
			end
		end
		// Sign of reference, or of target at standstill, with sense
		if (n.ref_v == 0) begin
			n.ccw = (tgt < 0) ^ s.sense;
		end else begin
			n.ccw = (n.ref_v < 0) ^ s.sense;
		end
		n.run = act_v;

		////////////////////////////////////////////////////////////////////////
		// AHB-Lite: writes zero-wait, reads take one wait state
		wa = s.addr;
		wd_s = $signed(hwdata);
		rd_v = 32'h0;
		wrate = 23'h0;
		unique case (1'b1)
			wa == A_MODE: rd_v = {24'h0, s.mode};
			wa == A_SENSE: rd_v = {31'h0, s.sense};
			wa >= A_FUNC0 && wa <= A_FUNC5: rd_v = {26'h0, s.func[3'(wa[7:2] - 6'h02)]};
			wa >= A_PRESET0 && wa <= A_PRESET7:
				rd_v = {{24{s.pre[wa[4:2]][7]}}, s.pre[wa[4:2]]};
			wa == A_RUP: rd_v = {9'h0, s.rup};
			wa == A_RDN: rd_v = {9'h0, s.rdn};
			wa == A_STAT: rd_v = {25'h0, dir_asg, s.run, s.ccw, idx, s.ref_v == tgt};
			wa == A_REF: rd_v = {{4{s.ref_v[27]}}, s.ref_v};
			default: rd_v = 32'h0;
		endcase
		if (s.wp) begin
			n.wp = 1'b0;
			unique case (1'b1)
				wa == A_MODE: n.mode = hwdata[7:0];
				wa == A_SENSE: n.sense = hwdata[0];
				wa >= A_FUNC0 && wa <= A_FUNC5: n.func[3'(wa[7:2] - 6'h02)] = hwdata[5:0];
				wa >= A_PRESET0 && wa <= A_PRESET7: begin
					if (wd_s > 32'(PRE_MAX)) begin
						n.pre[wa[4:2]] = PRE_MAX;
					end else if (wd_s < 32'(PRE_MIN)) begin
						n.pre[wa[4:2]] = PRE_MIN;
					end else begin
						n.pre[wa[4:2]] = hwdata[7:0];
					end
				end
				wa == A_RUP || wa == A_RDN: begin
					if (hwdata < 32'(RATE_MIN)) begin
						wrate = RATE_MIN;
					end else if (hwdata > 32'(RATE_MAX)) begin
						wrate = RATE_MAX;
					end else begin
						wrate = hwdata[22:0];
					end
					if (wa == A_RUP) begin
						n.rup = wrate;
					end else begin
						n.rdn = wrate;
					end
				end
				default: n.wp = 1'b0;
			endcase
		end
		if (s.rp) begin
			n.rp = 1'b0;
			n.rdy = 1'b1;
			n.rdata = rd_v;
		end
		if (hsel && hready && htrans[1] && s.rdy) begin
			n.addr = {haddr[7:2], 2'b00};
			n.wp = hwrite;
			n.rp = ~hwrite;
			n.rdy = hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '{sy1: '0, sy2: '0, mode: MODE_RST, sense: 1'b0,
				func: {N_IN{FN_RST}}, pre: PRE_RST, rup: RATE_RST,
				rdn: RATE_RST, tcnt: 16'h0, ref_v: 28'sh0, ccw: 1'b0,
				run: 1'b0, wp: 1'b0, rp: 1'b0, addr: 8'h0, rdy: 1'b1,
				rdata: 32'h0};
		end else if (ce) begin
			s <= n;
		end
	end

	assign hreadyout = s.rdy;
	assign hrdata = s.rdata;
	assign hresp = 1'b0;
	assign speed_ref = s.ref_v;
	assign dir_ccw = s.ccw;
	assign vel_run = s.run;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence rd_accept;
		ce && hsel && hready && htrans[1] && !hwrite && hreadyout;
	endsequence
	sequence rd_done;
		!hreadyout ##1 (ce && hreadyout);
	endsequence
	sequence wr_accept;
		ce && hsel && hready && htrans[1] && hwrite && hreadyout;
	endsequence

	a_read_wait_state: assert property (rd_accept ##1 ce |-> rd_done)
		else $error("read wait state wrong");
	a_ref_in_range: assert property (speed_ref <= 28'sd100000000 &&
		speed_ref >= -28'sd100000000) else $error("reference out of range");
	a_preset_clamped: assert property (s.wp && ce && wa >= A_PRESET0 &&
		wa <= A_PRESET7 |=> $signed(s.pre[$past(wa[4:2])]) <= PRE_MAX &&
		$signed(s.pre[$past(wa[4:2])]) >= PRE_MIN) else $error("preset not clamped");
	a_rate_range: assert property (s.rup >= RATE_MIN && s.rup <= RATE_MAX &&
		s.rdn >= RATE_MIN && s.rdn <= RATE_MAX) else $error("rate out of range");
	a_ramp_on_tick: assert property (!(tick && ce) |=> $stable(speed_ref))
		else $error("reference moved off tick");
	a_ramp_step: assert property (tick && ce && tgt != s.ref_v |=>
		speed_ref != $past(speed_ref)
		&& (speed_ref - $past(speed_ref) <= $signed(28'(RATE_MAX)))
		&& ($past(speed_ref) - speed_ref <= $signed(28'(RATE_MAX))))
		else $error("ramp step wrong");
	a_run_mode: assert property (ce |=> vel_run == $past(act_v))
		else $error("run not tied to mode and start");
	a_dir_sense: assert property (ce && n.ref_v != 0 |=>
		dir_ccw == ((speed_ref < 0) ^ $past(s.sense))) else $error("direction wrong");
	a_dir_input: assert property (act_v && dir_asg && pre_s != 0 |->
		(tgt > 0) == dir_on) else $error("direction input ignored");
	a_index_select: assert property (act_v && !dir_asg |->
		tgt == 28'($signed(s.pre[{sel_v[2], sel_v[1], sel_v[0]}]) * URPS))
		else $error("preset index wrong");

	// Bus timing, register writes and mode gating of run
	a_write_no_wait: assert property (wr_accept |=> hreadyout)
		else $error("write inserted a wait state");
	a_mode_gate: assert property (ce && s.mode != MODE_IVEL |=> !vel_run)
		else $error("run outside internal velocity mode");
	a_func_write: assert property (s.wp && ce && wa == A_FUNC0 |=>
		s.func[0] == $past(hwdata[5:0])) else $error("function code not stored");
	a_sense_write: assert property (s.wp && ce && wa == A_SENSE |=>
		s.sense == $past(hwdata[0])) else $error("sense not stored");
	a_preset_exact: assert property (s.wp && ce && wa == A_PRESET7 &&
		wd_s <= 32'(PRE_MAX) && wd_s >= 32'(PRE_MIN) |=>
		s.pre[7] == $past(hwdata[7:0])) else $error("in-range preset altered");
	a_rate_floor: assert property (s.wp && ce && wa == A_RDN &&
		hwdata < 32'(RATE_MIN) |=> s.rdn == RATE_MIN) else $error("rate floor wrong");
	a_rate_ceiling: assert property (s.wp && ce && wa == A_RDN &&
		hwdata > 32'(RATE_MAX) |=> s.rdn == RATE_MAX) else $error("rate ceiling wrong");

	// Ramp steps and direction
	a_ramp_rise: assert property (tick && ce &&
		diff > $signed({6'h0, rate}) |=>
		speed_ref - $past(speed_ref) == $signed({5'h0, $past(rate)}))
		else $error("rising step wrong");
	a_ramp_fall: assert property (tick && ce &&
		diff < -$signed({6'h0, rate}) |=>
		$past(speed_ref) - speed_ref == $signed({5'h0, $past(rate)}))
		else $error("falling step wrong");
	a_ramp_land: assert property (tick && ce &&
		diff <= $signed({6'h0, rate}) && diff >= -$signed({6'h0, rate}) |=>
		speed_ref == $past(tgt)) else $error("ramp did not land on target");
	a_ccw_standstill: assert property (ce && n.ref_v == 0 |=>
		dir_ccw == (($past(tgt) < 0) ^ $past(s.sense)))
		else $error("standstill direction wrong");
	a_dir_inactive: assert property (act_v && dir_asg && !dir_on && pre_s != 0 |->
		tgt < 0) else $error("inactive direction input not negative");
endmodule

// >>> verification/ipvs_sw_model.sv
// Switch bank model driving the general input contacts of the selector
module ipvs_sw_model
	import ipvs_pkg::*;
(
	input  wire logic           hclk,
	input  wire logic [2:0]     sel_idx,
	input  wire logic           run_act,
	input  wire logic           dir_act,
	input  wire logic           sel_open,
	input  wire logic           run_open,
	input  wire logic           dir_open,
	output logic [N_IN-1:0]     gen_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [N_IN-1:0] in_r = '0;
	logic            spare_r = 1'b0;
	assign gen_in = in_r;
	// Unassigned line chatters; all select contacts share one polarity
	always @(posedge hclk) begin
		spare_r <= ~spare_r;
		in_r    <= {spare_r, dir_act ^ dir_open, run_act ^ run_open, sel_idx ^ {3{sel_open}}};
	end
endmodule

// >>> verification/ipvs_tb_top.sv
// Self-checking bench for the internal preset velocity selector
module ipvs_tb_top
	import ipvs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 20;
	logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, d;
	logic [1:0] htrans = '0;
	logic hreadyout, hresp, dir_ccw, vel_run, dir_act = 0, sel_open = 0, run_open = 0;
	logic run_act = 0, dir_open = 0, sense = 0, dir_on = 0, run_on = 0;
	logic ce = 1'b1;
	logic [2:0] sel_idx = '0;
	logic [N_IN-1:0] gen_in;
	logic signed [27:0] speed_ref, prev_ref = '0;
	int error_cnt = 0, cmp_count = 0, lim = 100000, dlt, i, v;
	int pre[8] = '{0, 10, 20, 25, 30, 35, 40, 50};
	always #12.5 hclk = ~hclk;
	ipvs_top #(.TICK(TK)) u_ipvs_top (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.gen_in(gen_in), .speed_ref(speed_ref), .dir_ccw(dir_ccw), .vel_run(vel_run));
	ipvs_sw_model u_ipvs_sw_model (.hclk(hclk), .sel_idx(sel_idx), .run_act(run_act),
		.dir_act(dir_act), .sel_open(sel_open), .run_open(run_open), .dir_open(dir_open),
		.gen_in(gen_in));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge hclk);
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, '0);
		chk("register", exp, d);
	endtask
	function automatic logic [31:0] exp_ref(input int p);
		int a;
		a = p < 0 ? -p : p;
		if (!run_on)
			return 0;
		if (dir_on)
			return (dir_act ? a : -a) * 1000000;
		return p * 1000000;
	endfunction
	// Sense flips both tables; direction input decides when assigned
	function automatic logic exp_ccw(input int p);
		return dir_on ? (~dir_act ^ sense) : ((p < 0) ^ sense);
	endfunction
	task automatic apply(input int idx);
		sel_idx <= 3'(idx);
		repeat (45 * TK) @(posedge hclk);
		chk("speed_ref", exp_ref(pre[idx]), speed_ref);
		chk("dir_ccw", 32'(exp_ccw(pre[idx])), 32'(dir_ccw));
		chk("vel_run", 32'(run_on), 32'(vel_run));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Reference never jumps by more than one ramp step per clock
	always @(posedge hclk) begin
		dlt = speed_ref - prev_ref;
		prev_ref <= speed_ref;
		if (hresetn && (dlt > lim || -dlt > lim))
			chk("ramp_step", 32'(lim), 32'(dlt));
	end
	initial begin
		repeat (60000) @(posedge hclk);
		error_cnt++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'hb3669788));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(A_MODE, 32'd21);
		rchk(A_RUP, 32'd100000);
		rchk(A_RDN, 32'd100000);
		for (i = 0; i < 8; i++)
			rchk(8'(A_PRESET0 + 4 * i), pre[i]);
		rchk(8'h50, '0);
		chk("hresp", '0, 32'(hresp));
		bus(A_PRESET0, 1, -200);
		rchk(A_PRESET0, -100);
		bus(A_PRESET7, 1, 200);
		rchk(A_PRESET7, 100);
		bus(A_RDN, 1, 0);
		rchk(A_RDN, 167);
		bus(A_RDN, 1, 32'h00ffffff);
		rchk(A_RDN, 5000000);
		bus(A_MODE, 1, 15);
		for (i = 0; i < 4; i++)
			bus(8'(A_FUNC0 + 4 * i), 1, 27 + 2 * i);
		sel_idx <= 3'd1;
		run_act <= 1'b1;
		run_on = 1;
		repeat (5 * TK) @(posedge hclk);
		if (speed_ref < 1 || speed_ref > 500000 || speed_ref % 100000 != 0)
			chk("ramp_partial", 32'd100000, speed_ref);
		// Clock enable low must freeze the ramp in mid-flight
		ce <= 1'b0;
		@(posedge hclk);
		v = speed_ref;
		repeat (3 * TK) @(posedge hclk);
		chk("ce_freeze", v, speed_ref);
		ce <= 1'b1;
		lim = 5000000;
		bus(A_RUP, 1, 5000000);
		for (i = 0; i < 8; i++) begin
			v = $urandom_range(100, 1);
			pre[i] = $urandom_range(1, 0) ? -v : v;
			bus(8'(A_PRESET0 + 4 * i), 1, pre[i]);
		end
		for (v = 0; v < 2; v++) begin
			sense = v[0];
			bus(A_SENSE, 1, v);
			for (i = 0; i < 8; i++)
				apply((i * 5 + v) % 8);
		end
		bus(8'(A_FUNC0 + 16), 1, 35);
		dir_on = 1;
		for (v = 0; v < 4; v++) begin
			sense = v[1];
			dir_act <= v[0];
			bus(A_SENSE, 1, v[1]);
			apply($urandom_range(7, 0));
		end
		for (i = 0; i < 5; i++)
			bus(8'(A_FUNC0 + 4 * i), 1, 28 + 2 * i);
		sel_open <= 1'b1;
		run_open <= 1'b1;
		dir_open <= 1'b1;
		apply(6);
		rchk(A_REF, exp_ref(pre[6]));
		rchk(A_STAT, {25'h0, 1'b1, 1'b1, exp_ccw(pre[6]), 3'd6, 1'b1});
		rchk(8'(A_FUNC0 + 16), 32'd36);
		run_act <= 1'b0;
		run_on = 0;
		apply(2);
		bus(A_MODE, 1, 21);
		run_act <= 1'b1;
		apply(3);
		end_of_test();
	end
endmodule
